// >>> core/flash_cmd_map.svh
// Address map, command codes and field constants of the command decoder
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
// ==========================================================
// Register offsets and bus response codes
`define REG_CYC_ADDR 8'h00
`define REG_CYC_WRITE 8'h04
`define REG_CYC_READ 8'h08
`define REG_STATE 8'h0c
`define REG_PMR 8'h10
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// ==========================================================
// Command cycle values
`define CMD_ADDR_BITS 11
`define SECT_LSB 17
`define ADDR_UNLOCK1 11'h555
`define ADDR_UNLOCK2 11'h2aa
`define DATA_UNLOCK1 8'haa
`define DATA_UNLOCK2 8'h55
`define CMD_RESET 8'hf0
`define CMD_RESET_ALT 8'hff
`define CMD_ID_ENTRY 8'h90
`define CMD_QUERY_ENTRY 8'h98
`define CMD_SSR_ENTRY 8'h88
`define CMD_PROGRAM 8'ha0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECT_ERASE 8'h30
`define CMD_ERASE_SUSP 8'hb0
`define CMD_ERASE_RESUME 8'h30
`define CMD_PROG_SUSP 8'h51
`define CMD_PROG_RESUME 8'h50
`define CMD_BLANK_CHECK 8'h33
`define CMD_EVAL_ERASE 8'hd0
`define CMD_PWD_PROG 8'he4
`define CMD_PMR_PROG 8'he5
`define CMD_VLOCK_SET 8'he0
`define CMD_VLOCK_CLR 8'he1
`define CMD_PLOCK_PROG 8'he2
`define CMD_PROT_STAT 8'he3
`define CMD_VLOCK_READ 8'he6
// ==========================================================
// Field layouts
`define PMR_RESET 16'hffff
`define PMR_PLOCK_BIT 1
`define PMR_PWLOCK_BIT 2
`define ONES_STAT 13'h1fff
`define ONES_LOCK 15'h7fff
`endif

// >>> core/flash_cmd_pkg.sv
// Types shared by the command decoder
package flash_cmd_pkg;
  typedef enum logic [2:0] {MODE_READ, MODE_ID, MODE_SSR, MODE_ABORT, MODE_ERASE_SUSP, MODE_PROG_SUSP} mode_t;
  typedef enum logic [3:0] {SEQ_IDLE, SEQ_UNL1, SEQ_UNL2, SEQ_PROG, SEQ_PWD, SEQ_PMR,
                            SEQ_ER0, SEQ_ER1, SEQ_ER2} seq_t;
  typedef enum logic [1:0] {RDK_NONE, RDK_PROT, RDK_VLOCK} rdk_t;
endpackage

// >>> core/flash_command_sequence_decoder.sv
// Command-sequence decoder of the flash device with its register slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "flash_cmd_map.svh"
module flash_command_sequence_decoder import flash_cmd_pkg::*; #(
  parameter int AW = 25
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic erase_active,
  input wire logic program_active,
  input wire logic buf_abort,
  input wire logic status_error_bit,
  input wire logic [AW-1:0] erasing_addr,
  input wire logic [15:0] array_rdata,
  input wire logic [15:0] ovl_rdata,
  output logic [AW-1:0] array_addr_r,
  output logic ovl_ssr_r,
  output logic prog_req_r,
  output logic [AW-1:0] prog_addr_r,
  output logic [15:0] prog_data_r,
  output logic erase_req_r,
  output logic erase_chip_r,
  output logic [AW-1:0] erase_addr_r,
  output logic erase_susp_req_r,
  output logic erase_resume_req_r,
  output logic prog_susp_req_r,
  output logic prog_resume_req_r,
  output logic blank_req_r,
  output logic eval_req_r,
  output logic err_clear_req_r
);
  localparam int NSECT = 2 ** (AW - `SECT_LSB);
  localparam int SW = AW - `SECT_LSB;

  function automatic logic [SW-1:0] sector_of(input logic [AW-1:0] a);
    return a[AW-1:`SECT_LSB];
  endfunction

  // ==========================================================
  // Reset release
  logic rst_m_r, rst_s_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end
  wire rst_n = rst_s_r;

  // ==========================================================
  // Register bus slave
  logic aw_have_r, w_have_r, ar_have_r, rd_pend_r;
  logic [7:0] awaddr_q_r, araddr_q_r;
  logic [31:0] wdata_q_r;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
  wire do_rd = rd_pend_r;
  wire aw_have_nxt = aw_fire || (aw_have_r && !do_wr);
  wire w_have_nxt = w_fire || (w_have_r && !do_wr);
  wire bvalid_nxt = do_wr || (s_axi_bvalid && !s_axi_bready);
  wire ar_have_nxt = ar_fire || (ar_have_r && !(s_axi_rvalid && s_axi_rready));
  wire wr_known = awaddr_q_r == `REG_CYC_ADDR || awaddr_q_r == `REG_CYC_WRITE;
  wire rd_known = araddr_q_r == `REG_CYC_ADDR || araddr_q_r == `REG_CYC_READ ||
                  araddr_q_r == `REG_STATE || araddr_q_r == `REG_PMR;
  // Command cycles are writes, data reads are read cycles
  wire wr_cyc = do_wr && awaddr_q_r == `REG_CYC_WRITE;
  wire rd_cyc = do_rd && araddr_q_r == `REG_CYC_READ;

  // ==========================================================
  // Decode of one command cycle
  mode_t mode_r, mode_nxt;
  seq_t seq_r, seq_nxt;
  rdk_t rdk_r, rdk_nxt;
  logic [AW-1:0] cyc_addr_r;
  logic [15:0] pmr_r;
  logic [1:0] pwd_idx_r;
  logic [15:0] pwd_r [4];
  logic psusp_in_erase_r;
  // Only a running sector erase may be suspended, never a chip erase
  logic sect_erase_r;
  logic [SW-1:0] rd_sect_r;
  logic [NSECT-1:0] vlock_r, plock_r;
  // Only the low address bits and low data byte steer decoding
  wire [10:0] ca = cyc_addr_r[`CMD_ADDR_BITS-1:0];
  wire [7:0] cd = wdata_q_r[7:0];
  wire at555 = ca == `ADDR_UNLOCK1;
  wire is_u1 = at555 && cd == `DATA_UNLOCK1;
  wire is_u2 = ca == `ADDR_UNLOCK2 && cd == `DATA_UNLOCK2;
  wire is_exit = cd == `CMD_RESET || cd == `CMD_RESET_ALT;
  wire in_ovl = mode_r == MODE_ID || mode_r == MODE_SSR;
  wire [SW-1:0] cyc_sect = sector_of(cyc_addr_r);
  wire prog_blocked = mode_r == MODE_ERASE_SUSP && cyc_sect == sector_of(erasing_addr);
  wire pmr_both = !wdata_q_r[`PMR_PLOCK_BIT] && !wdata_q_r[`PMR_PWLOCK_BIT];
  // A new status command retargets the sector even while a word is pending
  wire rdk_cmd = wr_cyc && seq_r == SEQ_UNL2 && mode_r == MODE_READ &&
                 (cd == `CMD_PROT_STAT || cd == `CMD_VLOCK_READ);
  logic prog_go, erase_go, chip_go, esusp_go, eres_go, psusp_go, pres_go;
  logic blank_go, eval_go, errclr_go, pwd_we, pmr_we, vset_go, vclr_go, pprog_go;

  always_comb begin
    mode_nxt = mode_r;
    seq_nxt = seq_r;
    rdk_nxt = rd_cyc ? RDK_NONE : rdk_r;
    {prog_go, erase_go, chip_go, esusp_go, eres_go, psusp_go, pres_go} = '0;
    {blank_go, eval_go, errclr_go, pwd_we, pmr_we, vset_go, vclr_go, pprog_go} = '0;
    if (buf_abort && mode_r == MODE_READ) begin
      mode_nxt = MODE_ABORT;
    end
    if (wr_cyc) begin
      seq_nxt = SEQ_IDLE;
      case (seq_r)
        SEQ_IDLE: begin
          if (is_u1) begin
            seq_nxt = SEQ_UNL1;
          end else if (is_exit) begin
            if (in_ovl) mode_nxt = MODE_READ;
            else if (mode_r == MODE_READ && status_error_bit) errclr_go = 1'b1;
          end else if (cd == `CMD_QUERY_ENTRY && at555 && (mode_r == MODE_READ || mode_r == MODE_ID)) begin
            mode_nxt = MODE_ID;
          end else if (cd == `CMD_ERASE_SUSP && mode_r == MODE_READ && erase_active && sect_erase_r) begin
            mode_nxt = MODE_ERASE_SUSP;
            esusp_go = 1'b1;
          end else if (cd == `CMD_ERASE_RESUME && mode_r == MODE_ERASE_SUSP) begin
            mode_nxt = MODE_READ;
            eres_go = 1'b1;
          end else if (cd == `CMD_PROG_SUSP && program_active &&
                       (mode_r == MODE_READ || mode_r == MODE_ERASE_SUSP)) begin
            mode_nxt = MODE_PROG_SUSP;
            psusp_go = 1'b1;
          end else if (cd == `CMD_PROG_RESUME && mode_r == MODE_PROG_SUSP) begin
            mode_nxt = psusp_in_erase_r ? MODE_ERASE_SUSP : MODE_READ;
            pres_go = 1'b1;
          end else if (mode_r == MODE_READ && at555) begin
            blank_go = cd == `CMD_BLANK_CHECK;
            eval_go = cd == `CMD_EVAL_ERASE;
          end
        end
        SEQ_UNL1: seq_nxt = is_u2 ? SEQ_UNL2 : SEQ_IDLE;
        SEQ_UNL2: begin
          case (cd)
            `CMD_RESET: if (at555 && (mode_r == MODE_ABORT || in_ovl)) mode_nxt = MODE_READ;
            `CMD_ID_ENTRY: if (mode_r == MODE_READ || mode_r == MODE_ID || mode_r == MODE_ERASE_SUSP)
              mode_nxt = MODE_ID;
            `CMD_SSR_ENTRY: if (mode_r == MODE_READ) mode_nxt = MODE_SSR;
            `CMD_PROGRAM: if (mode_r != MODE_ABORT && mode_r != MODE_PROG_SUSP) seq_nxt = SEQ_PROG;
            `CMD_ERASE_SETUP: if (mode_r == MODE_READ && at555) seq_nxt = SEQ_ER0;
            `CMD_PWD_PROG: if (mode_r == MODE_READ) seq_nxt = SEQ_PWD;
            `CMD_PMR_PROG: if (mode_r == MODE_READ) seq_nxt = SEQ_PMR;
            // Any address inside the sector selects it
            `CMD_VLOCK_SET: vset_go = mode_r == MODE_READ;
            `CMD_VLOCK_CLR: vclr_go = mode_r == MODE_READ;
            `CMD_PLOCK_PROG: pprog_go = mode_r == MODE_READ;
            `CMD_PROT_STAT: if (mode_r == MODE_READ) rdk_nxt = RDK_PROT;
            `CMD_VLOCK_READ: if (mode_r == MODE_READ) rdk_nxt = RDK_VLOCK;
            default: seq_nxt = SEQ_IDLE;
          endcase
        end
        SEQ_PROG: prog_go = !prog_blocked;
        SEQ_PWD: pwd_we = ca[1:0] == pwd_idx_r;
        SEQ_PMR: begin
          if (pmr_both) mode_nxt = MODE_READ;
          else pmr_we = 1'b1;
        end
        SEQ_ER0: seq_nxt = is_u1 ? SEQ_ER1 : SEQ_IDLE;
        SEQ_ER1: seq_nxt = is_u2 ? SEQ_ER2 : SEQ_IDLE;
        SEQ_ER2: begin
          chip_go = at555 && cd == `CMD_CHIP_ERASE;
          erase_go = cd == `CMD_SECT_ERASE || chip_go;
        end
        default: seq_nxt = SEQ_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Read data selection
  wire v_n = !vlock_r[rd_sect_r];
  wire p_n = !plock_r[rd_sect_r];
  // Protection status word lock bit word
  wire [15:0] prot_word = {`ONES_STAT, p_n, v_n, v_n && p_n};
  wire [15:0] lock_word = {`ONES_LOCK, v_n};
  // One-shot words, then overlay or array data
  wire [15:0] cyc_rword = rdk_r == RDK_PROT ? prot_word : rdk_r == RDK_VLOCK ? lock_word :
                          in_ovl ? ovl_rdata : array_rdata;
  wire [31:0] rd_word = araddr_q_r == `REG_CYC_ADDR ? {{(32-AW){1'b0}}, cyc_addr_r} :
                        araddr_q_r == `REG_CYC_READ ? {16'h0000, cyc_rword} :
                        araddr_q_r == `REG_STATE ? {22'h0, pwd_idx_r, 1'b0, seq_r, mode_r} :
                        araddr_q_r == `REG_PMR ? {16'h0000, pmr_r} : 32'h0000_0000;

  // ==========================================================
  // Bus state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {aw_have_r, w_have_r, ar_have_r, rd_pend_r} <= 4'h0;
      {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h0;
      {s_axi_bvalid, s_axi_rvalid} <= 2'h0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      awaddr_q_r <= 8'h00;
      araddr_q_r <= 8'h00;
      wdata_q_r <= 32'h0000_0000;
      cyc_addr_r <= '0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      ar_have_r <= ar_have_nxt;
      rd_pend_r <= ar_fire;
      s_axi_awready <= !aw_have_nxt && !bvalid_nxt;
      s_axi_wready <= !w_have_nxt && !bvalid_nxt;
      s_axi_arready <= !ar_have_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (aw_fire) awaddr_q_r <= s_axi_awaddr;
      if (w_fire) wdata_q_r <= s_axi_wdata;
      if (ar_fire) araddr_q_r <= s_axi_araddr;
      if (do_wr) s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      // Address register holds a word address
      if (do_wr && awaddr_q_r == `REG_CYC_ADDR) cyc_addr_r <= wdata_q_r[AW-1:0];
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Decoder state and command outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_READ;
      seq_r <= SEQ_IDLE;
      rdk_r <= RDK_NONE;
      psusp_in_erase_r <= 1'b0;
      sect_erase_r <= 1'b0;
      rd_sect_r <= '0;
      {prog_req_r, erase_req_r, erase_chip_r, erase_susp_req_r, erase_resume_req_r} <= 5'h00;
      {prog_susp_req_r, prog_resume_req_r, blank_req_r, eval_req_r, err_clear_req_r} <= 5'h00;
      prog_addr_r <= '0;
      prog_data_r <= 16'h0000;
      erase_addr_r <= '0;
      array_addr_r <= '0;
      ovl_ssr_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      seq_r <= seq_nxt;
      rdk_r <= rdk_nxt;
      if (psusp_go) psusp_in_erase_r <= mode_r == MODE_ERASE_SUSP;
      if (rdk_cmd) rd_sect_r <= cyc_sect;
      {prog_req_r, erase_req_r, erase_chip_r, erase_susp_req_r, erase_resume_req_r} <=
        {prog_go, erase_go, chip_go, esusp_go, eres_go};
      {prog_susp_req_r, prog_resume_req_r, blank_req_r, eval_req_r, err_clear_req_r} <=
        {psusp_go, pres_go, blank_go, eval_go, errclr_go};
      // Program data keeps its upper byte
      if (prog_go) prog_data_r <= wdata_q_r[15:0];
      if (prog_go) prog_addr_r <= cyc_addr_r;
      // Full word address kept so small sectors see bits 16 to 11
      if (erase_go) erase_addr_r <= cyc_addr_r;
      if (erase_go) sect_erase_r <= !chip_go;
      array_addr_r <= cyc_addr_r;
      ovl_ssr_r <= mode_nxt == MODE_SSR;
    end
  end

  // ==========================================================
  // One-time programmable store; only ones can turn into zeros
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pmr_r <= `PMR_RESET;
      pwd_idx_r <= 2'h0;
      for (int i = 0; i < 4; i++) pwd_r[i] <= 16'hffff;
    end else begin
      if (pmr_we) pmr_r <= pmr_r & wdata_q_r[15:0];
      if (pwd_we) begin
        pwd_r[pwd_idx_r] <= pwd_r[pwd_idx_r] & wdata_q_r[15:0];
        pwd_idx_r <= pwd_idx_r + 2'h1;
      end
    end
  end

  // Per-sector locks; nonvolatile bits are modelled as cleared by reset
  for (genvar s = 0; s < NSECT; s++) begin : g_sect
    wire hit = cyc_sect == SW'(s);
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        vlock_r[s] <= 1'b0;
        plock_r[s] <= 1'b0;
      end else begin
        if (hit && vset_go) vlock_r[s] <= 1'b1;
        else if (hit && vclr_go) vlock_r[s] <= 1'b0;
        if (hit && pprog_go) plock_r[s] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_exit_cycle;
    wr_cyc && seq_r == SEQ_IDLE && is_exit;
  endsequence
  a_erase_susp_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    erase_susp_req_r |-> $past(erase_active) && mode_r == MODE_ERASE_SUSP)
    else $error("erase suspend without erase");
  a_resume_from_susp: assert property (@(posedge core_clk) disable iff (!rst_n)
    erase_resume_req_r |-> $past(mode_r) == MODE_ERASE_SUSP && mode_r == MODE_READ)
    else $error("erase resume outside suspend");
  a_abort_single_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_exit_cycle and (mode_r == MODE_ABORT) |=> mode_r == MODE_ABORT)
    else $error("abort left by single reset");
  a_overlay_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_exit_cycle and in_ovl |=> mode_r == MODE_READ)
    else $error("overlay not left on exit");
  a_query_entry_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_cyc && seq_r == SEQ_IDLE && cd == `CMD_QUERY_ENTRY && mode_r == MODE_ABORT |=> mode_r == MODE_ABORT)
    else $error("query entry accepted in wrong state");
  a_pmr_otp_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pmr_r & ~$past(pmr_r)) == 16'h0000)
    else $error("protection mode bit erased");
  a_read_array_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_cyc && mode_r == MODE_READ && rdk_r == RDK_NONE |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(array_rdata))
    else $error("array read data wrong");
  a_status_one_shot: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_cyc && rdk_r == RDK_PROT |=> rdk_r == RDK_NONE && s_axi_rdata[15:3] == `ONES_STAT)
    else $error("status word not one-shot");
  a_pwd_ascending: assert property (@(posedge core_clk) disable iff (!rst_n)
    pwd_we |-> ca[1:0] == pwd_idx_r ##1 pwd_idx_r == $past(pwd_idx_r) + 2'h1)
    else $error("password portion out of order");
  a_pwd_skip_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_cyc && seq_r == SEQ_PWD && ca[1:0] != pwd_idx_r |=> $stable(pwd_idx_r))
    else $error("password portion taken out of order");
endmodule

// >>> dv/engine_model.sv
// Program and erase engine stand-in facing the command decoder
`timescale 1ns/10ps
module engine_model #(
  parameter int AW = 25
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic prog_req_r,
  input wire logic prog_susp_req_r,
  input wire logic prog_resume_req_r,
  input wire logic erase_req_r,
  input wire logic erase_susp_req_r,
  input wire logic erase_resume_req_r,
  input wire logic [AW-1:0] erase_addr_r,
  input wire logic [AW-1:0] array_addr_r,
  output logic erase_active,
  output logic program_active,
  output logic [AW-1:0] erasing_addr,
  output logic [15:0] array_rdata,
  output logic [15:0] ovl_rdata
);
  // ==========================================================
  // Busy timers
  int pcnt;
  int ecnt;
  // Finite busy times, so a missed suspend cannot block later traffic
  assign program_active = pcnt != 0;
  assign erase_active = ecnt != 0;
  // Array and overlay contents differ, so a wrong source shows at once
  assign array_rdata = array_addr_r[15:0] ^ 16'h5a5a;
  assign ovl_rdata = ~array_addr_r[15:0];
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcnt <= 0;
      ecnt <= 0;
      erasing_addr <= '0;
    end else begin
      pcnt <= (prog_req_r || prog_resume_req_r) ? 40 : (prog_susp_req_r || pcnt == 0) ? 0 : pcnt - 1;
      ecnt <= (erase_req_r || erase_resume_req_r) ? 400 : (erase_susp_req_r || ecnt == 0) ? 0 : ecnt - 1;
      if (erase_req_r) erasing_addr <= erase_addr_r;
    end
  end
endmodule

// >>> dv/flash_command_sequence_decoder_test.sv
// Self-checking bench of the command decoder
`timescale 1ns/10ps
module flash_command_sequence_decoder_test import flash_cmd_pkg::*;;
  localparam int AW = 25;
  logic core_clk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, buf_abort = 0, status_error_bit = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, erase_active, program_active;
  logic ovl_ssr_r, prog_req_r, erase_req_r, erase_chip_r, erase_susp_req_r, erase_resume_req_r;
  logic prog_susp_req_r, prog_resume_req_r, blank_req_r, eval_req_r, err_clear_req_r;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [AW-1:0] erasing_addr, array_addr_r, prog_addr_r, erase_addr_r, pa;
  logic [15:0] array_rdata, ovl_rdata, prog_data_r, pd;
  logic [9:0] pv;
  int pc[10], p0[10], error_cnt = 0, check_count = 0;
  initial begin forever #10 core_clk = ~core_clk; end
  flash_command_sequence_decoder #(.AW(AW)) flash_command_sequence_decoder_inst (.core_clk, .rst_b,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .erase_active, .program_active, .buf_abort, .status_error_bit,
    .erasing_addr, .array_rdata, .ovl_rdata, .array_addr_r, .ovl_ssr_r, .prog_req_r, .prog_addr_r, .prog_data_r,
    .erase_req_r, .erase_chip_r, .erase_addr_r, .erase_susp_req_r, .erase_resume_req_r, .prog_susp_req_r,
    .prog_resume_req_r, .blank_req_r, .eval_req_r, .err_clear_req_r);
  engine_model #(.AW(AW)) engine_model_inst (.core_clk, .rst_b, .prog_req_r, .prog_susp_req_r,
    .prog_resume_req_r, .erase_req_r, .erase_susp_req_r, .erase_resume_req_r, .erase_addr_r, .array_addr_r,
    .erase_active, .program_active, .erasing_addr, .array_rdata, .ovl_rdata);
  // ==========================================================
  // Pulse counters
  assign pv = {erase_chip_r, err_clear_req_r, eval_req_r, blank_req_r, prog_resume_req_r, prog_susp_req_r,
    erase_resume_req_r, erase_susp_req_r, erase_req_r, prog_req_r};
  always @(posedge core_clk) begin
    for (int i = 0; i < 10; i++) if (pv[i]) pc[i]++;
    if (prog_req_r) begin
      pa <= prog_addr_r;
      pd <= prog_data_r;
    end
  end
  // ==========================================================
  // Bus tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta;
    logic tw;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    ta = 0;
    tw = 0;
    // Each channel is released only after the edge that takes it
    while (!(ta && tw) && n < 40) begin
      @(negedge core_clk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      n++;
    end
    do begin @(negedge core_clk); n++; end while (s_axi_bvalid !== 1 && n < 40);
    tmo(n);
    rr = s_axi_bresp;
    @(posedge core_clk);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin @(negedge core_clk); n++; end while (s_axi_arready !== 1 && n < 40);
    @(posedge core_clk);
    s_axi_arvalid <= 0;
    do begin @(negedge core_clk); n++; end while (s_axi_rvalid !== 1 && n < 40);
    tmo(n);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 0;
  endtask
  task automatic cmd(input logic [24:0] a, input logic [15:0] d);
    wr(8'h00, 32'(a));
    wr(8'h04, {16'h0, d});
  endtask
  // Junk in the high address bits and high data byte on every unlock
  task automatic unl();
    cmd(25'h1e0555, 16'hc3aa);
    cmd(25'h0ff2aa, 16'h7e55);
  endtask
  task automatic cm(input mode_t e);
    rd(8'h0c);
    chk({29'h0, rv[2:0]}, {29'h0, e});
  endtask
  task automatic arr(input logic [24:0] a);
    wr(8'h00, 32'(a));
    repeat (2) @(posedge core_clk);
    rd(8'h08);
  endtask
  task automatic cp(input int i, input int e);
    @(negedge core_clk);
    chk(32'(pc[i] - p0[i]), 32'(e));
  endtask
  task automatic pmr(input logic [15:0] d);
    unl();
    cmd(25'h555, 16'h00e5);
    cmd(25'h0, d);
    rd(8'h10);
  endtask
  task automatic pr(input logic [7:0] c);
    unl();
    cmd(25'h0a6555, {8'h0, c});
    arr(25'h0a0000);
  endtask
  task automatic pw(input logic [1:0] p);
    unl();
    cmd(25'h555, 16'h00e4);
    cmd({23'h0, p}, 16'h1234);
    rd(8'h0c);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_base();
    cm(MODE_READ);
    arr(25'h012345);
    chk(rv, 32'h2345 ^ 32'h5a5a);
    rd(8'h40);
    chk({30'h0, rr}, 32'h2);
    chk(rv, 32'h0);
    p0 = pc;
    status_error_bit <= 1;
    cmd(25'h0, 16'h00f0);
    status_error_bit <= 0;
    cp(8, 1);
    $display("base done");
  endtask
  task automatic t_ovl();
    unl();
    cmd(25'h555, 16'h0090);
    cm(MODE_ID);
    arr(25'h1);
    chk(rv, 32'hfffe);
    cmd(25'h555, 16'h0098);
    cm(MODE_ID);
    cmd(25'h0, 16'h00f0);
    cm(MODE_READ);
    cmd(25'h555, 16'h0098);
    arr(25'h1);
    chk(rv, 32'hfffe);
    cmd(25'h0, 16'h00ff);
    cm(MODE_READ);
    unl();
    cmd(25'h555, 16'h0088);
    cmd(25'h555, 16'h0098);
    cm(MODE_SSR);
    chk({31'h0, ovl_ssr_r}, 32'h1);
    cmd(25'h0, 16'h00f0);
    cm(MODE_READ);
    $display("overlay done");
  endtask
  task automatic t_abort();
    buf_abort <= 1;
    @(posedge core_clk);
    buf_abort <= 0;
    cm(MODE_ABORT);
    cmd(25'h0, 16'h00f0);
    cm(MODE_ABORT);
    cmd(25'h555, 16'h0098);
    cm(MODE_ABORT);
    unl();
    cmd(25'h555, 16'h00f0);
    cm(MODE_READ);
    $display("abort done");
  endtask
  task automatic t_prot();
    pmr(16'hfff9);
    chk({30'h0, rv[2:1]}, 32'h3);
    cm(MODE_READ);
    chk({28'h0, rv[6:3]}, 32'h0);
    pmr(16'hfffd);
    chk({30'h0, rv[2:1]}, 32'h2);
    pmr(16'hffff);
    chk({30'h0, rv[2:1]}, 32'h2);
    pr(8'he3);
    chk(rv, 32'hffff);
    arr(25'h0a0000);
    chk(rv, 32'h5a5a);
    unl();
    cmd(25'h0b8555, 16'h00e0);
    pr(8'he3);
    chk(rv, 32'hfffc);
    pr(8'he6);
    chk(rv, 32'hfffe);
    unl();
    cmd(25'h0a0555, 16'h00e1);
    pr(8'he6);
    chk(rv, 32'hffff);
    unl();
    cmd(25'h0bf555, 16'h00e2);
    pr(8'he3);
    chk(rv, 32'hfffa);
    pw(2'h0);
    chk({30'h0, rv[9:8]}, 32'h1);
    pw(2'h2);
    chk({30'h0, rv[9:8]}, 32'h1);
    pw(2'h1);
    chk({30'h0, rv[9:8]}, 32'h2);
    $display("protection done");
  endtask
  task automatic t_prog();
    p0 = pc;
    unl();
    cmd(25'h555, 16'h00a0);
    cmd(25'h1c2345, 16'hbeef);
    cp(0, 1);
    chk({16'h0, pd}, 32'hbeef);
    chk(32'(pa), 32'h1c2345);
    cmd(25'h0, 16'h0051);
    cm(MODE_PROG_SUSP);
    cmd(25'h0, 16'h0030);
    cm(MODE_PROG_SUSP);
    cmd(25'h0, 16'h0050);
    cm(MODE_READ);
    repeat (60) @(posedge core_clk);
    cmd(25'h555, 16'h0033);
    cmd(25'h555, 16'h00d0);
    cp(6, 1);
    cp(7, 1);
    cp(5, 1);
    cp(4, 1);
    $display("program done");
  endtask
  task automatic t_erase();
    p0 = pc;
    cmd(25'h0, 16'h00b0);
    cmd(25'h0, 16'h0030);
    cm(MODE_READ);
    cp(2, 0);
    unl();
    cmd(25'h555, 16'h0080);
    unl();
    cmd(25'h0a5800, 16'h0030);
    cp(1, 1);
    cp(9, 0);
    chk(32'(erase_addr_r), 32'h0a5800);
    cmd(25'h0, 16'h00b0);
    cm(MODE_ERASE_SUSP);
    cmd(25'h0, 16'h0050);
    cm(MODE_ERASE_SUSP);
    p0 = pc;
    unl();
    cmd(25'h555, 16'h00a0);
    cmd(25'h0a0010, 16'h1111);
    cp(0, 0);
    unl();
    cmd(25'h555, 16'h00a0);
    cmd(25'h0c0010, 16'h2222);
    cp(0, 1);
    cmd(25'h0, 16'h0051);
    cm(MODE_PROG_SUSP);
    cmd(25'h0, 16'h0050);
    cm(MODE_ERASE_SUSP);
    cmd(25'h0, 16'h0030);
    cm(MODE_READ);
    cp(3, 1);
    p0 = pc;
    unl();
    cmd(25'h555, 16'h0080);
    unl();
    cmd(25'h555, 16'h0010);
    cp(9, 1);
    cmd(25'h0, 16'h00b0);
    cm(MODE_READ);
    cp(2, 0);
    $display("erase done");
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1;
    repeat (5) @(posedge core_clk);
    t_base();
    t_ovl();
    t_abort();
    t_prot();
    t_prog();
    t_erase();
    summarize();
  end
endmodule
